// ### logic/sdadc_pkg.sv
package sdadc_pkg;
    localparam int WORD_W = 20;
    localparam int CLK_HZ = 25000000;
    // nominal master clock of the converter
    localparam int MCLK_HZ = 4096000;
    localparam int RATE_HZ = 4000;
    // output word period in master clocks (mclk/1024)
    localparam int WORD_DIV = MCLK_HZ / RATE_HZ;
    localparam logic [9:0] WORD_DIV_LAST = 10'(WORD_DIV - 1);
    localparam logic [2:0] LOAD_CYC = 3'h4;
    localparam logic [2:0] CAL_MIN = 3'h4;
    localparam logic [4:0] BIT_LAST = 5'h13;
    localparam logic [11:0] CAL_CYC = 12'h800;
    localparam logic [1:0] SCLK_PHASE_HI = 2'h3;
    localparam logic [WORD_W-1:0] BIPOLAR_FLIP = 20'h80000;
    typedef enum logic [1:0] {
        SDADC_IDLE = 2'b00,
        SDADC_SHIFT = 2'b01,
        SDADC_DONE = 2'b10
    } sdadc_tx_t;
    typedef enum logic [1:0] {
        SDADC_RUN = 2'b00,
        SDADC_HELD = 2'b01,
        SDADC_TRIM = 2'b10
    } sdadc_cal_t;
endpackage

// ### logic/sdadc_shift.sv
`timescale 1ns/10ps
// serial shifter: external clocked or self clocked, msb first
module sdadc_shift (
    input wire logic clk,
    input wire logic rst_b,
    sdadc_word_if.dst wif,
    input wire logic self_clocked_mode,
    input wire logic chip_select_n,
    input wire logic sclk_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic sclk_out,
    output logic sclk_oe,
    output logic word_done
);
    typedef struct packed {
        sdadc_pkg::sdadc_tx_t st;
        logic [19:0] sh;
        logic [4:0] cnt;
        logic [1:0] ph;
        logic sclk_d;
        logic sclk_o;
        logic oe;
        logic done;
    } sdadc_sh_t;
    sdadc_sh_t s_r, s_nxt;
    logic fall;
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.sclk_d = sclk_in;
        fall = 1'b0;
        case (s_r.st)
            sdadc_pkg::SDADC_IDLE: begin
                s_nxt.oe = 1'b0;
                s_nxt.sclk_o = 1'b0;
                if (!chip_select_n && wif.load) begin
                    s_nxt.st = sdadc_pkg::SDADC_SHIFT;
                    s_nxt.sh = wif.word;
                    s_nxt.cnt = '0;
                    s_nxt.ph = '0;
                    s_nxt.oe = 1'b1;
                end
            end
            sdadc_pkg::SDADC_SHIFT: begin
                if (self_clocked_mode) begin
                    s_nxt.ph = s_r.ph + 2'h1;
                    s_nxt.sclk_o = (s_r.ph == (sdadc_pkg::SCLK_PHASE_HI - 2'h1));
                    fall = (s_r.ph == sdadc_pkg::SCLK_PHASE_HI);
                end else begin
                    fall = s_r.sclk_d && !sclk_in;
                    // host clock resting low: no bit in flight, so a release floats at once
                    if (chip_select_n && !s_r.sclk_d && !sclk_in) begin
                        s_nxt.st = sdadc_pkg::SDADC_IDLE;
                        s_nxt.oe = 1'b0;
                    end
                end
                if (fall) begin
                    s_nxt.sh = {s_r.sh[18:0], 1'b0};
                    s_nxt.cnt = s_r.cnt + 5'h1;
                    if (s_r.cnt == sdadc_pkg::BIT_LAST) begin
                        s_nxt.st = sdadc_pkg::SDADC_DONE;
                        s_nxt.done = 1'b1;
                    end else if (chip_select_n) begin
                        s_nxt.st = sdadc_pkg::SDADC_IDLE;
                        s_nxt.oe = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.oe = 1'b0;
                s_nxt.sclk_o = 1'b0;
                if (chip_select_n) begin
                    s_nxt.st = sdadc_pkg::SDADC_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign serial_out = s_r.sh[19];
    assign serial_out_oe = s_r.oe;
    assign sclk_out = s_r.sclk_o;
    assign sclk_oe = self_clocked_mode;
    assign word_done = s_r.done;
    assign wif.busy = (s_r.st == sdadc_pkg::SDADC_SHIFT);
    a_sclk_duty: assert property (@(posedge clk) disable iff (!rst_b)
        s_r.sclk_o |=> !s_r.sclk_o) else $error("sclk high longer than one cycle");
    a_float_abort: assert property (@(posedge clk) disable iff (!rst_b)
        (s_r.st == sdadc_pkg::SDADC_IDLE) |-> !s_r.oe) else $error("output driven idle");
endmodule // sdadc_shift

// ### logic/sdadc_top.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - sleep pin low stops conversion and word updates.
// - polarity pin low selects unipolar range, high selects bipolar range.
// - calibration request high over 4 clocks resets; calibration runs on fall.
// - calibration accepted any time; parameters kept for later conversions.
// - chip select low starts shifting in the chosen serial mode.
// - word valid flag low while a valid word is held.
// - word valid flag high once a complete word is sent.
// - word valid flag forced high four clocks while a new word loads.
// - shift clock direction by mode; self clocked runs at clock/4, 25% duty.
// - each result leaves as one 20-bit serial word.
// - output register refreshed at the fixed word rate.
// - mode low: external shift clock, coded word msb first; high: self clocked.
// - trim kind pins sampled on the calibration request rising edge.
// - chip select released early finishes the bit then floats the serial data output.
// - unipolar straight binary, bipolar offset binary.
//////////////////////////////////////////////////////////////////////////////
module sdadc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sleep_n,
    input wire logic input_polarity_select,
    input wire logic cal_request,
    input wire logic [1:0] trim_kind_select,
    input wire logic serial_mode,
    input wire logic chip_select_n,
    input wire logic sclk_in,
    input wire logic [19:0] filter_result,
    output logic sclk_out,
    output logic sclk_oe,
    output logic serial_out,
    output logic serial_out_oe,
    output logic word_valid_n,
    output logic [1:0] trim_kind,
    output logic cal_busy,
    output logic standby
);
    typedef struct packed {
        sdadc_pkg::sdadc_cal_t cst;
        logic [9:0] div;
        logic [2:0] ldc;
        logic [2:0] calc;
        logic [11:0] trimc;
        logic [19:0] out_word;
        logic [1:0] kind;
        logic [19:0] trim_ofs;
        logic valid;
        logic cal_d;
        logic load;
        logic vn;
        logic sclk_o;
        logic sclk_e;
        logic sd_o;
        logic sd_e;
        logic busy_o;
        logic stby;
    } sdadc_top_st_t;
    sdadc_top_st_t t_r, t_nxt;
    sdadc_word_if wif ();
    logic sh_sd, sh_sde, sh_sclk, sh_sclke, sh_done;

    // raw result to output code; the filter delivers a two's complement value
    function automatic logic [19:0] code_of(input logic [19:0] raw, input logic bip);
        code_of = bip ? (raw ^ sdadc_pkg::BIPOLAR_FLIP) : raw;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        t_nxt = t_r;
        t_nxt.cal_d = cal_request;
        t_nxt.load = 1'b0;
        t_nxt.stby = !sleep_n;
        if (cal_request && !t_r.cal_d) begin
            t_nxt.kind = trim_kind_select;
        end
        case (t_r.cst)
            sdadc_pkg::SDADC_RUN: begin
                t_nxt.calc = '0;
                if (cal_request) begin
                    t_nxt.cst = sdadc_pkg::SDADC_HELD;
                    // the first high cycle counts, so five high cycles are enough
                    t_nxt.calc = 3'h1;
                end
            end
            sdadc_pkg::SDADC_HELD: begin
                if (cal_request && t_r.calc <= sdadc_pkg::CAL_MIN) begin
                    t_nxt.calc = t_r.calc + 3'h1;
                end
                if (t_r.calc > sdadc_pkg::CAL_MIN) begin
                    // held long enough: device resets its word timing
                    t_nxt.div = '0;
                    t_nxt.valid = 1'b0;
                    t_nxt.ldc = '0;
                end
                if (!cal_request) begin
                    t_nxt.cst = (t_r.calc > sdadc_pkg::CAL_MIN) ? sdadc_pkg::SDADC_TRIM
                                                               : sdadc_pkg::SDADC_RUN;
                    t_nxt.trimc = '0;
                end
            end
            default: begin
                t_nxt.trimc = t_r.trimc + 12'h1;
                if (cal_request) begin
                    t_nxt.cst = sdadc_pkg::SDADC_HELD;
                    t_nxt.calc = 3'h1;
                end else if (t_r.trimc == sdadc_pkg::CAL_CYC) begin
                    // trim value kept for later conversions until the next calibration completes
                    t_nxt.trim_ofs = filter_result;
                    t_nxt.cst = sdadc_pkg::SDADC_RUN;
                end
            end
        endcase
        // word timer; halted in sleep, reset and calibration
        if (sleep_n && t_r.cst == sdadc_pkg::SDADC_RUN) begin
            if (t_r.div == sdadc_pkg::WORD_DIV_LAST) begin
                t_nxt.div = '0;
                t_nxt.ldc = sdadc_pkg::LOAD_CYC;
                // flag rises at the wrap so it stands high for the full load window
                t_nxt.valid = 1'b0;
            end else begin
                t_nxt.div = t_r.div + 10'h1;
            end
        end
        if (t_r.ldc != '0) begin
            t_nxt.ldc = t_r.ldc - 3'h1;
            t_nxt.valid = 1'b0;
            if (t_r.ldc == 3'h1) begin
                t_nxt.out_word = code_of(filter_result - t_r.trim_ofs,
                                         input_polarity_select);
                t_nxt.valid = 1'b1;
            end
        end else if (sh_done) begin
            t_nxt.valid = 1'b0;
        end
        // shifter is armed only while word valid is low and chip select is low
        t_nxt.load = t_r.valid && t_r.ldc == '0 && !chip_select_n && !wif.busy;
        t_nxt.vn = !(t_nxt.valid);
        t_nxt.sclk_o = sh_sclk;
        t_nxt.sclk_e = sh_sclke;
        t_nxt.sd_o = sh_sd;
        t_nxt.sd_e = sh_sde;
        t_nxt.busy_o = (t_nxt.cst != sdadc_pkg::SDADC_RUN);
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            t_r <= '0;
            t_r.vn <= 1'b1;
            t_r.cal_d <= 1'b1;
        end else begin
            t_r <= t_nxt;
        end
    end
    assign wif.load = t_r.load;
    assign wif.word = t_r.out_word;

    sdadc_shift u_shift (
        .clk(clk),
        .rst_b(rst_b),
        .wif(wif),
        .self_clocked_mode(serial_mode),
        .chip_select_n(chip_select_n),
        .sclk_in(sclk_in),
        .serial_out(sh_sd),
        .serial_out_oe(sh_sde),
        .sclk_out(sh_sclk),
        .sclk_oe(sh_sclke),
        .word_done(sh_done)
    );

    assign sclk_out = t_r.sclk_o;
    assign sclk_oe = t_r.sclk_e;
    assign serial_out = t_r.sd_o;
    assign serial_out_oe = t_r.sd_e;
    assign word_valid_n = t_r.vn;
    assign trim_kind = t_r.kind;
    assign cal_busy = t_r.busy_o;
    assign standby = t_r.stby;

    //////////////////////////////////////////////////////////////////////////
    a_load_gap: assert property (@(posedge clk) disable iff (!rst_b)
        (t_r.ldc == sdadc_pkg::LOAD_CYC) |-> word_valid_n [*4] ##1 !word_valid_n)
        else $error("word valid low during load");
    a_sleep_halt: assert property (@(posedge clk) disable iff (!rst_b)
        !sleep_n |=> $stable(t_r.div)) else $error("timer ran in sleep");
    a_done_clears: assert property (@(posedge clk) disable iff (!rst_b)
        (sh_done && t_r.ldc == '0) |=> ##1 word_valid_n)
        else $error("word valid stayed low after word");
    a_cal_reset: assert property (@(posedge clk) disable iff (!rst_b)
        (t_r.cst == sdadc_pkg::SDADC_HELD && t_r.calc > sdadc_pkg::CAL_MIN) |=> t_r.div == '0)
        else $error("timer not reset by calibration");
    a_trim_sample: assert property (@(posedge clk) disable iff (!rst_b)
        (cal_request && !t_r.cal_d) |=> ##1 trim_kind == $past(trim_kind_select, 2))
        else $error("trim kind not sampled");
    a_word_rate: assert property (@(posedge clk) disable iff (!rst_b)
        (t_r.ldc == sdadc_pkg::LOAD_CYC) |=> t_r.ldc != sdadc_pkg::LOAD_CYC [*8])
        else $error("word loads too close");
    a_sclk_dir: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (sclk_oe == $past(serial_mode)))
        else $error("shift clock direction wrong");
    a_float_out: assert property (@(posedge clk) disable iff (!rst_b)
        !sh_sde |=> !serial_out_oe) else $error("serial out not floated");
    c_word_sent: cover property (@(posedge clk) sh_done);
    c_cal_run: cover property (@(posedge clk) t_r.cst == sdadc_pkg::SDADC_TRIM);
    c_self_clk: cover property (@(posedge clk) sclk_out && sclk_oe);
endmodule // sdadc_top

// ### logic/sdadc_word_if.sv
`timescale 1ns/10ps
interface sdadc_word_if;
    logic load;
    logic [19:0] word;
    logic busy;
    modport src (output load, output word, input busy);
    modport dst (input load, input word, output busy);
endinterface

// ### verif/sdadc_host.sv
`timescale 1ns/10ps
// host side: reads one word per call in either serial mode
module sdadc_host (
    input wire logic clk,
    input wire logic serial_mode,
    input wire logic word_valid_n,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    output logic chip_select_n,
    output logic sclk_in
);
    logic hclk = 1'b0;
    logic junk = 1'b0;
    initial chip_select_n = 1'b1;
    always @(posedge clk) junk <= ~junk;
    // an undriven pin shows a changing pattern, never a stale level
    assign sclk_in = sclk_oe ? sclk_out : (serial_mode ? junk : hclk);
    task automatic read_word(output logic [19:0] w, output int span);
        int b;
        int first;
        w = 20'h00000;
        span = 0;
        b = 0;
        first = 0;
        @(negedge clk) chip_select_n = 1'b0;
        if (serial_mode) begin
            for (int n = 0; n < 200 && b < 20; n++) begin
                @(negedge clk);
                if (sclk_out === 1'b1 && serial_out_oe === 1'b1) begin
                    w = {w[18:0], serial_out};
                    if (b == 0) first = n;
                    span = n - first;
                    b++;
                end
            end
        end else begin
            // first edge held off so the armed msb is already out
            repeat (8) @(negedge clk);
            for (b = 0; b < 20; b++) begin
                hclk = 1'b1;
                repeat (4) @(negedge clk);
                w = {w[18:0], serial_out_oe === 1'b1 ? serial_out : 1'bx};
                hclk = 1'b0;
                repeat (4) @(negedge clk);
            end
        end
        chip_select_n = 1'b1;
    endtask
    task automatic early(input int k);
        @(negedge clk) chip_select_n = 1'b0;
        repeat (k) @(negedge clk);
        chip_select_n = 1'b1;
    endtask
endmodule // sdadc_host

// ### verif/test_sigma_delta_adc_serial_port.sv
`timescale 1ns/10ps
module test_sigma_delta_adc_serial_port;
    logic clk, rst_b, sleep_n, input_polarity_select, cal_request, serial_mode;
    logic chip_select_n, sclk_in, sclk_out, sclk_oe, serial_out, serial_out_oe;
    logic word_valid_n, cal_busy, standby, v0;
    logic [1:0] trim_kind_select, trim_kind;
    logic [19:0] filter_result, w, off;
    int err_count = 0, checks = 0, span, n;
    sdadc_top sdadc_top_i (.clk, .rst_b, .sleep_n, .input_polarity_select, .cal_request,
        .trim_kind_select, .serial_mode, .chip_select_n, .sclk_in, .filter_result,
        .sclk_out, .sclk_oe, .serial_out, .serial_out_oe, .word_valid_n, .trim_kind,
        .cal_busy, .standby);
    sdadc_host sdadc_host_i (.clk, .serial_mode, .word_valid_n, .serial_out,
        .serial_out_oe, .sclk_out, .sclk_oe, .chip_select_n, .sclk_in);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [19:0] exp_word(logic [19:0] f, logic p);
        return (f - off) ^ (p ? sdadc_pkg::BIPOLAR_FLIP : 20'h00000);
    endfunction
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_vld(input logic v);
        for (n = 0; word_valid_n !== v && n < 1200; n++) tick(1);
        chk(20'(word_valid_n), 20'(v));
    endtask
    task automatic calib(input logic [1:0] k, input logic [19:0] f);
        trim_kind_select = k;
        filter_result = f;
        tick(1);
        cal_request = 1'b1;
        tick(5);
        chk(20'(trim_kind), 20'(k));
        cal_request = 1'b0;
        tick(2);
        chk(20'(cal_busy), 20'h00001);
        for (n = 0; cal_busy !== 1'b0 && n < 2200; n++) tick(1);
        chk(20'(cal_busy), 20'h00000);
        off = f;
        $display("test calibration kind %0d done", k);
    endtask
    // entered with the flag high so the next load takes the new value
    task automatic rd(input logic m, input logic p, input logic [19:0] f);
        serial_mode = m;
        input_polarity_select = p;
        filter_result = f;
        wait_vld(1'b0);
        chk(20'(sclk_oe), 20'(m));
        sdadc_host_i.read_word(w, span);
        chk(w, exp_word(f, p));
        if (m) chk(20'(span), 20'h0004c);
        tick(8);
        chk(20'(word_valid_n), 20'h00001);
        $display("test read mode %0d polarity %0d done", m, p);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        tick(60000);
        err_count++;
        summarize();
    end
    initial begin
        {rst_b, input_polarity_select, cal_request, serial_mode} = 4'h0;
        sleep_n = 1'b1;
        trim_kind_select = 2'h0;
        filter_result = 20'h00000;
        off = 20'h00000;
        void'($urandom(32'hfa6c));
        tick(4);
        rst_b = 1'b1;
        tick(1);
        chk(20'({word_valid_n, serial_out_oe, sclk_oe}), 20'h00004);
        for (int k = 0; k < 4; k++) calib(2'(k), 20'h00000);
        // a strobe of four cycles is too short to start a calibration
        cal_request = 1'b1;
        tick(4);
        cal_request = 1'b0;
        tick(10);
        chk(20'(cal_busy), 20'h00000);
        for (int i = 0; i < 8; i++) rd(i[0], i[1], 20'($urandom));
        rd(1'b1, 1'b1, 20'h7ffff);
        rd(1'b0, 1'b0, 20'hfffff);
        wait_vld(1'b0);
        wait_vld(1'b1);
        for (n = 0; word_valid_n === 1'b1 && n < 10; n++) tick(1);
        chk(20'(n), 20'h00004);
        for (; word_valid_n === 1'b0 && n < 1100; n++) tick(1);
        chk(20'(n), 20'h00400);
        wait_vld(1'b0);
        sdadc_host_i.early(12);
        tick(8);
        chk(20'(serial_out_oe), 20'h00000);
        $display("test early release done");
        sleep_n = 1'b0;
        tick(2);
        chk(20'(standby), 20'h00001);
        v0 = word_valid_n;
        for (n = 0; word_valid_n === v0 && n < 1100; n++) tick(1);
        chk(20'(n), 20'h0044c);
        sleep_n = 1'b1;
        $display("test sleep done");
        calib(2'($urandom), 20'h00123);
        rd(1'b1, 1'b0, 20'h54321);
        rd(1'b0, 1'b1, 20'h0abcd);
        summarize();
    end
endmodule // test_sigma_delta_adc_serial_port
